// [exposure_start_pkg.sv]
// shared constants and types for the exposure start trigger block
package exposure_start_pkg;

  // trigger origins
  typedef enum logic [2:0] {
    SRC_SOFTWARE   = 3'h0,
    SRC_HOST_TOGGLE = 3'h1,
    SRC_LINK       = 3'h2,
    SRC_TIMER      = 3'h3,
    SRC_OPTO       = 3'h4
  } start_origin_t;

  // acquisition modes
  typedef enum logic [1:0] {
    ACQ_CONTINUOUS = 2'h0,
    ACQ_SINGLE     = 2'h1,
    ACQ_MULTI      = 2'h2
  } acq_mode_t;

  // exposure state machine
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_WAIT    = 2'h1,
    ST_TIMED   = 2'h2,
    ST_PULSE   = 2'h3
  } expo_state_t;

  localparam int TIME_W = 32;
  localparam int COUNT_W = 16;
  localparam logic [TIME_W-1:0] TIME_ZERO = 32'h00000000;
  localparam logic [TIME_W-1:0] TIME_ONE = 32'h00000001;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // settings that steer the block
  typedef struct packed {
    logic external_start_enable;
    start_origin_t start_origin_select;
    logic edge_polarity_select;     // 1 = rising
    logic exposure_length_policy;   // 1 = pulse_length
    logic timer_sense_select;       // 1 = level type
    acq_mode_t acq_mode;
    logic [COUNT_W-1:0] burst_frame_total;
    logic [TIME_W-1:0] exposure_duration_setting;
    logic [TIME_W-1:0] timer_pulse_length;
    logic [TIME_W-1:0] free_run_period;   // cycles, from free_run_rate_setting
    logic [TIME_W-1:0] min_frame_period;  // cycles, from maximum allowed rate
  } trig_cfg_t;

  // raw trigger inputs
  typedef struct packed {
    logic host_toggle_bit;
    logic link_event;
    logic delay_timer_active;
    logic opto_input;
  } trig_in_t;

  // block state
  typedef struct packed {
    expo_state_t state;
    logic [1:0] link_sync;
    logic [1:0] opto_sync;
    logic [1:0] timer_sync;
    logic sel_prev;
    logic src_valid;
    logic [TIME_W-1:0] expo_cnt;
    logic [TIME_W-1:0] rate_cnt;
    logic [COUNT_W-1:0] frame_cnt;
    logic stop_pending;
    logic exposure_active;
    logic exposure_start;
    logic waiting_for_start;
    logic acquisition_active;
    logic start_dropped;
  } trig_state_t;

endpackage : exposure_start_pkg

// [exposure_start_trigger_control.sv]
// exposure start trigger control: free run, triggered starts and exposure length
// Function
// - Only one trigger type exists: the exposure start event beginning a frame.
// - Trigger off: internal starts from acquisition start until acquisition stop.
// - Free run below maximum rate produces starts at the programmed rate.
// - Free run above maximum rate is clamped to the maximum rate.
// - Trigger off: exposure length equals the programmed exposure duration.
// - Trigger on: starts accepted only from the selected origin of five.
// - Polarity setting picks rising or falling transition as the start.
// - Software starts always use the programmed exposure duration.
// - Link or opto: fixed uses duration, pulse follows trigger active level.
// - Timer pulse policy: edge sense uses timer length, level sense follows signal.
// - Host toggle: fixed uses duration, pulse exposes between on and off.
// - Software start while waiting begins frame exposure.
// - Leave waiting on exposure start; return once another start is acceptable.
// - Software starts outside the waiting state are discarded.
// - Link source starts a frame on the chosen edge when waiting.
// - Opto source level is the hardware start, polarity picks its edge.
// - Each valid link trigger period yields exactly one frame.
// - No frames before acquisition start; idle after stop until next start.
// - Multi frame mode stops itself after the burst frame total.
// - Pulse policy: exposure spans active edge to the following opposite edge.
// - Start events during an exposure in progress are ignored.
module exposure_start_trigger_control (
  input wire logic clk,
  input wire logic sys_rst,
  input exposure_start_pkg::trig_cfg_t cfg,
  input exposure_start_pkg::trig_in_t trig_in,
  input wire logic acquisition_start_cmd,
  input wire logic acquisition_stop_cmd,
  input wire logic soft_fire_command,
  output logic exposure_active,
  output logic exposure_start,
  output logic waiting_for_start,
  output logic acquisition_active,
  output logic start_dropped
);

  exposure_start_pkg::trig_state_t s_reg;
  exposure_start_pkg::trig_state_t s_next;

  // combinational helpers
  logic sel_level;
  logic sel_active;
  logic edge_hit;
  logic start_req;
  logic pulse_mode;
  logic [exposure_start_pkg::TIME_W-1:0] eff_period;
  logic [exposure_start_pkg::TIME_W-1:0] fixed_len;
  logic last_frame;

  // select the source level; link, timer and opto after synchronisation, host toggle direct
  always_comb begin
    unique case (cfg.start_origin_select)
      exposure_start_pkg::SRC_HOST_TOGGLE: sel_level = trig_in.host_toggle_bit;
      exposure_start_pkg::SRC_LINK: sel_level = s_reg.link_sync[1];
      exposure_start_pkg::SRC_TIMER: sel_level = s_reg.timer_sync[1];
      exposure_start_pkg::SRC_OPTO: sel_level = s_reg.opto_sync[1];
      default: sel_level = 1'b0;
    endcase
  end

  // edge detect, start request and exposure length choice
  always_comb begin
    sel_active = cfg.edge_polarity_select ? sel_level : ~sel_level;
    edge_hit = s_reg.src_valid && sel_active && (s_reg.sel_prev != sel_active);
    eff_period = (cfg.free_run_period < cfg.min_frame_period) ? cfg.min_frame_period
                                                              : cfg.free_run_period;
    if (!cfg.external_start_enable) begin
      start_req = (s_reg.rate_cnt == exposure_start_pkg::TIME_ZERO);
    end else if (cfg.start_origin_select == exposure_start_pkg::SRC_SOFTWARE) begin
      start_req = soft_fire_command;
    end else begin
      start_req = edge_hit;
    end
    // pulse tracking only for external origins under pulse policy
    pulse_mode = cfg.external_start_enable && cfg.exposure_length_policy &&
                 (cfg.start_origin_select != exposure_start_pkg::SRC_SOFTWARE) &&
                 !((cfg.start_origin_select == exposure_start_pkg::SRC_TIMER) &&
                   !cfg.timer_sense_select);
    if (cfg.external_start_enable && cfg.exposure_length_policy &&
        (cfg.start_origin_select == exposure_start_pkg::SRC_TIMER)) begin
      fixed_len = cfg.timer_pulse_length;
    end else begin
      fixed_len = cfg.exposure_duration_setting;
    end
    last_frame = (cfg.acq_mode == exposure_start_pkg::ACQ_SINGLE) ||
                 ((cfg.acq_mode == exposure_start_pkg::ACQ_MULTI) &&
                  (s_reg.frame_cnt + exposure_start_pkg::COUNT_ONE >= cfg.burst_frame_total));
  end

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.exposure_start = 1'b0;
    s_next.start_dropped = 1'b0;
    // two flop synchronisers
    s_next.link_sync = {s_reg.link_sync[0], trig_in.link_event};
    s_next.opto_sync = {s_reg.opto_sync[0], trig_in.opto_input};
    s_next.timer_sync = {s_reg.timer_sync[0], trig_in.delay_timer_active};
    s_next.sel_prev = sel_active;
    s_next.src_valid = 1'b1;
    // free-run pacing counter
    if (s_reg.rate_cnt != exposure_start_pkg::TIME_ZERO) begin
      s_next.rate_cnt = s_reg.rate_cnt - exposure_start_pkg::TIME_ONE;
    end
    if (acquisition_stop_cmd) begin
      s_next.stop_pending = 1'b1;
    end
    unique case (s_reg.state)
      exposure_start_pkg::ST_IDLE: begin
        if (acquisition_start_cmd) begin
          s_next.state = exposure_start_pkg::ST_WAIT;
          s_next.frame_cnt = exposure_start_pkg::COUNT_ZERO;
          s_next.rate_cnt = exposure_start_pkg::TIME_ZERO;
          s_next.stop_pending = 1'b0;
        end
      end
      exposure_start_pkg::ST_WAIT: begin
        if (s_reg.stop_pending || acquisition_stop_cmd) begin
          s_next.state = exposure_start_pkg::ST_IDLE;
          s_next.stop_pending = 1'b0;
        end else if (start_req) begin
          s_next.exposure_start = 1'b1;
          s_next.frame_cnt = s_reg.frame_cnt + exposure_start_pkg::COUNT_ONE;
          s_next.rate_cnt = eff_period - exposure_start_pkg::TIME_ONE;
          if (last_frame) begin
            s_next.stop_pending = 1'b1;
          end
          if (pulse_mode) begin
            s_next.state = exposure_start_pkg::ST_PULSE;
          end else begin
            s_next.state = exposure_start_pkg::ST_TIMED;
            s_next.expo_cnt = fixed_len;
          end
        end
      end
      exposure_start_pkg::ST_TIMED: begin
        if (s_reg.expo_cnt <= exposure_start_pkg::TIME_ONE) begin
          s_next.state = exposure_start_pkg::ST_WAIT;
        end else begin
          s_next.expo_cnt = s_reg.expo_cnt - exposure_start_pkg::TIME_ONE;
        end
        if (soft_fire_command || edge_hit) begin
          s_next.start_dropped = 1'b1;
        end
      end
      exposure_start_pkg::ST_PULSE: begin
        if (!sel_active) begin
          s_next.state = exposure_start_pkg::ST_WAIT;
        end
      end
    endcase
    s_next.exposure_active = (s_next.state == exposure_start_pkg::ST_TIMED) ||
                             (s_next.state == exposure_start_pkg::ST_PULSE);
    s_next.waiting_for_start = (s_next.state == exposure_start_pkg::ST_WAIT);
    s_next.acquisition_active = (s_next.state != exposure_start_pkg::ST_IDLE);
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.state <= exposure_start_pkg::ST_IDLE;
      s_reg.link_sync <= exposure_start_pkg::SYNC_RESET;
      s_reg.opto_sync <= exposure_start_pkg::SYNC_RESET;
      s_reg.timer_sync <= exposure_start_pkg::SYNC_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign exposure_active = s_reg.exposure_active;
  assign exposure_start = s_reg.exposure_start;
  assign waiting_for_start = s_reg.waiting_for_start;
  assign acquisition_active = s_reg.acquisition_active;
  assign start_dropped = s_reg.start_dropped;

endmodule : exposure_start_trigger_control

// [expo_trig_asserts.sv]
// checker for the exposure start trigger block
module expo_trig_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input exposure_start_pkg::trig_cfg_t cfg,
  input exposure_start_pkg::trig_in_t trig_in,
  input wire logic acquisition_start_cmd,
  input wire logic soft_fire_command,
  input wire logic exposure_active,
  input wire logic exposure_start,
  input wire logic waiting_for_start,
  input wire logic acquisition_active
);
  logic [31:0] act_reg, gap_reg, per;
  logic seen_reg, ext, sw;
  logic [2:0] org;
  // mode decode and clamped free-run spacing
  assign ext = cfg.external_start_enable;
  assign org = cfg.start_origin_select;
  assign sw = ext && org == 3'h0;
  assign per = cfg.free_run_period > cfg.min_frame_period ? cfg.free_run_period : cfg.min_frame_period;
  // exposure length and start spacing counters
  always_ff @(posedge clk) begin
    act_reg <= sys_rst || !exposure_active ? 32'h0 : act_reg + 32'h1;
    gap_reg <= exposure_start ? 32'h1 : gap_reg + 32'h1;
    seen_reg <= !sys_rst && acquisition_active && (seen_reg || exposure_start);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_fixed; $fell(exposure_active) && (!ext || sw || !cfg.exposure_length_policy)
    |-> act_reg == cfg.exposure_duration_setting; endproperty
  a_fixed: assert property (p_fixed) else $error("exposure length differs from setting");
  property p_spacing; exposure_start && !ext && seen_reg && cfg.exposure_duration_setting + 32'h2 < per
    |-> gap_reg == per; endproperty
  a_spacing: assert property (p_spacing) else $error("free-run spacing wrong");
  property p_link; $rose(trig_in.link_event) && waiting_for_start && ext && org == 3'h2
    && cfg.edge_polarity_select |-> ##[2:5] exposure_start; endproperty
  a_link: assert property (p_link) else $error("link edge did not start a frame");
  property p_opto; $fell(trig_in.opto_input) && waiting_for_start && ext && org == 3'h4
    && !cfg.edge_polarity_select |-> ##[2:5] exposure_start; endproperty
  a_opto: assert property (p_opto) else $error("opto edge did not start a frame");
  property p_soft; soft_fire_command && sw && waiting_for_start |=> exposure_start; endproperty
  a_soft: assert property (p_soft) else $error("software start not taken");
  property p_soft_drop; soft_fire_command && sw && !waiting_for_start |=> !exposure_start; endproperty
  a_soft_drop: assert property (p_soft_drop) else $error("software start not discarded");
  property p_leave; exposure_start |-> exposure_active && !waiting_for_start && $past(waiting_for_start); endproperty
  a_leave: assert property (p_leave) else $error("wait state not left on start");
  property p_return; $fell(exposure_active) && acquisition_active
    && cfg.acq_mode == exposure_start_pkg::ACQ_CONTINUOUS |-> waiting_for_start; endproperty
  a_return: assert property (p_return) else $error("wait state not re-entered");
  property p_busy; exposure_active |=> !exposure_start; endproperty
  a_busy: assert property (p_busy) else $error("start during exposure");
  property p_idle; !acquisition_active |-> !exposure_start && !exposure_active; endproperty
  a_idle: assert property (p_idle) else $error("frame while idle");
  property p_go; acquisition_start_cmd && !acquisition_active |=> acquisition_active; endproperty
  a_go: assert property (p_go) else $error("acquisition did not start");
  c_spacing: cover property (exposure_start && seen_reg && !ext);
  c_pulse: cover property ($fell(exposure_active) && cfg.exposure_length_policy);
  c_drop: cover property (soft_fire_command && sw && exposure_active);
endmodule : expo_trig_asserts

bind exposure_start_trigger_control expo_trig_asserts u_expo_trig_asserts (.clk, .sys_rst, .cfg, .trig_in,
  .acquisition_start_cmd, .soft_fire_command, .exposure_active, .exposure_start, .waiting_for_start,
  .acquisition_active);

// [trig_source.sv]
// host and trigger line model: one active pulse per request
module trig_source (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] width,
  input wire logic act_high,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg = 8'h00;
  // a request loads the pulse length; line rests at the inactive level
  always_ff @(posedge clk) begin
    left_reg <= go ? width : (left_reg != 8'h00 ? left_reg - 8'h01 : 8'h00);
  end
  assign line = (left_reg != 8'h00) ? act_high : !act_high;
endmodule : trig_source

// [exposure_start_trigger_control_test.sv]
// self-checking bench for the exposure start trigger block
module exposure_start_trigger_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, acq_go, acq_halt, soft_fire, go, line, ea, es, wfs, aa, sd;
  logic [7:0] width;
  logic [3:0] nz;
  exposure_start_pkg::trig_cfg_t cfg;
  exposure_start_pkg::trig_in_t trig_in;
  int n_mismatch, num_checks, len, e, n_drop, q[$];
  exposure_start_trigger_control u_exposure_start_trigger_control (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
    .trig_in(trig_in), .acquisition_start_cmd(acq_go), .acquisition_stop_cmd(acq_halt),
    .soft_fire_command(soft_fire), .exposure_active(ea), .exposure_start(es), .waiting_for_start(wfs),
    .acquisition_active(aa), .start_dropped(sd));
  trig_source u_trig_source (.clk(clk), .go(go), .width(width), .act_high(cfg.edge_polarity_select), .line(line));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // selected line from the model, the other lines toggle at random
  always @(negedge clk) begin
    nz = 4'($urandom);
    if (cfg.start_origin_select != exposure_start_pkg::SRC_SOFTWARE) nz[3'h4 - cfg.start_origin_select] = line;
    trig_in <= exposure_start_pkg::trig_in_t'(nz);
  end
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  // measure each exposure and compare with the oldest note (value*2, +1 allows one cycle slack)
  always @(negedge clk) begin
    if (sd === 1'b1) n_drop++;
    if (ea === 1'b1) len++;
    else if (len != 0) begin
      num_checks++;
      if (q.size() == 0) bad("unexpected frame");
      else begin
        e = q.pop_front();
        if (len > e / 2 + e % 2 || len + e % 2 < e / 2) bad("exposure length");
      end
      len = 0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic wait_for(ref logic s, input logic v);
    for (int i = 0; i < 300 && s !== v; i++) cyc(1);
    if (s !== v) bad("no response");
  endtask : wait_for
  task automatic drain;
    for (int i = 0; i < 300 && q.size() != 0; i++) cyc(1);
    if (q.size() != 0) bad("missing frame");
    cyc(4);
  endtask : drain
  // one triggered frame for a given origin, polarity and length policy
  task automatic frame(input int org, input logic pol, input logic pul);
    int d0;
    d0 = n_drop;
    cfg.start_origin_select = exposure_start_pkg::start_origin_t'(org);
    cfg.edge_polarity_select = pol;
    cfg.exposure_length_policy = pul;
    cfg.timer_sense_select = 1'($urandom);
    width = 8'(4 + $urandom % 8);
    cyc(6);
    pulse(acq_go);
    wait_for(wfs, 1'b1);
    if (org == 0 || !pul) q.push_back(2 * int'(cfg.exposure_duration_setting));
    else if (org == 3 && !cfg.timer_sense_select) q.push_back(2 * int'(cfg.timer_pulse_length));
    else q.push_back(2 * int'(width) + 1);
    if (org == 0) begin
      repeat (2) begin
        pulse(soft_fire);
        cyc(1);
      end
    end else pulse(go);
    drain();
    // second software start lands inside the timed exposure and must be flagged
    if (org == 0) begin
      num_checks++;
      if (n_drop != d0 + 1) bad("dropped start not flagged");
    end
    pulse(acq_halt);
    wait_for(aa, 1'b0);
  endtask : frame
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    void'($urandom(87807));
    {sys_rst, acq_go, acq_halt, soft_fire, go, width, trig_in, cfg} = '0;
    sys_rst = 1'b1;
    cfg.exposure_duration_setting = 32'(3 + $urandom % 8);
    cfg.timer_pulse_length = 32'(3 + $urandom % 8);
    cfg.min_frame_period = 32'h0000001E;
    cyc(2);
    sys_rst = 1'b0;
    repeat (2) begin
      cfg.free_run_period = 32'(20 + $urandom % 20);
      repeat (3) q.push_back(2 * int'(cfg.exposure_duration_setting));
      pulse(acq_go);
      repeat (3) begin
        wait_for(es, 1'b1);
        cyc(1);
      end
      pulse(acq_halt);
      drain();
      wait_for(aa, 1'b0);
    end
    cfg.external_start_enable = 1'b1;
    for (int o = 0; o < 5; o++) for (int p = 0; p < 4; p++) frame(o, p[0], p[1]);
    cfg.start_origin_select = exposure_start_pkg::SRC_SOFTWARE;
    cfg.burst_frame_total = 16'h0003;
    for (int m = 1; m < 3; m++) begin
      cfg.acq_mode = exposure_start_pkg::acq_mode_t'(m);
      repeat (m == 1 ? 1 : 3) q.push_back(2 * int'(cfg.exposure_duration_setting));
      pulse(acq_go);
      repeat (5) begin
        cyc(15);
        pulse(soft_fire);
      end
      drain();
      num_checks++;
      if (aa !== 1'b0) bad("acquisition still active");
    end
    complete_run();
  end
endmodule : exposure_start_trigger_control_test
